/* src_pkg.sv */
// src_pkg: constants, field positions and carrier types of the system reset controller.
// assumes a 32-bit ahb-lite register bus; registers sit at byte address = 4 * index.
`default_nettype none

package src_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_POWER_CONTROL_ZERO  = 8'h87;  // power_control_zero
  localparam logic [7:0] IDX_FLAGS  = 8'h97;  // power_reset_flags
  localparam logic [7:0] IDX_PROG   = 8'he7;  // programming_control
  localparam logic [7:0] IDX_SYSTEM_FLAG_IRQ_ENABLE   = 8'h8e;  // system_flag_irq_enable
  localparam logic [7:0] IDX_WDTC   = 8'he1;  // watchdog_control
  localparam logic [7:0] IDX_POWER_CONTROL_TWO  = 8'hf1;  // power_control_two
  localparam logic [7:0] IDX_CLKSEL = 8'hf2;  // clock source select and boot status

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int POWER_ON_FLAG_BIT   = 4;  // power_control_zero
  localparam int SOFT_CAUSE_BIT      = 7;  // power_reset_flags
  localparam int PIN_FLAG_BIT        = 6;
  localparam int MCLK_FLAG_BIT       = 5;
  localparam int SUPPLY_B_FLAG_BIT   = 2;
  localparam int SUPPLY_A_FLAG_BIT   = 1;
  localparam int WDOG_FLAG_BIT       = 0;
  localparam int PROG_ENABLE_BIT     = 7;  // programming_control
  localparam int BOOT_SELECT_BIT     = 6;
  localparam int SOFT_TRIGGER_BIT    = 5;
  localparam int PROG_FAIL_BIT       = 4;
  localparam int MCLK_RESET_EN_BIT   = 6;  // system_flag_irq_enable
  localparam int MCLK_IRQ_EN_BIT     = 5;
  localparam int WDOG_RESET_EN_BIT   = 7;  // watchdog_control
  localparam int SUPPLY_A_RST_EN_BIT = 1;  // power_control_two
  localparam int SUPPLY_B_RST_EN_BIT = 3;
  localparam int CRYSTAL_SEL_BIT     = 0;  // clock select register
  localparam int BOOT_STATUS_BIT     = 1;

  // ****************************************************************
  // reset values and implemented-bit masks
  // ****************************************************************
  localparam logic [7:0] POWER_CONTROL_ZERO_POR   = 8'h10;
  localparam logic [7:0] FLAGS_POR   = 8'h00;
  localparam logic [7:0] PROG_POR    = 8'h00;
  localparam logic [7:0] SYSTEM_FLAG_IRQ_ENABLE_POR    = 8'h60;
  localparam logic [7:0] WDTC_POR    = 8'h00;
  localparam logic [7:0] POWER_CONTROL_TWO_POR   = 8'h00;
  localparam logic [7:0] FLAGS_MASK  = 8'he7;  // rtc and stack flags live elsewhere
  localparam logic [7:0] PROG_MASK   = 8'hd0;  // trigger and low nibble read zero
  localparam logic [7:0] WDTC_MASK   = 8'h80;
  localparam logic [7:0] POWER_CONTROL_TWO_MASK  = 8'h0a;

  // ****************************************************************
  // timing counts and boot addresses
  // ****************************************************************
  localparam logic [4:0]  PIN_HOLD_CYCLES = 5'd24;  // oscillator periods = hclk periods
  localparam logic [2:0]  RST_HOLD_CYCLES = 3'd4;
  localparam logic [15:0] RESET_VECTOR    = 16'h0000;
  localparam logic [15:0] ISP_START       = 16'hf000;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic por_low;       // power-on detector: supply below threshold
    logic pin_level;     // external reset pin, active high
    logic illegal_addr;  // fetch from an illegal address, pulse
    logic detector_a;    // fixed-level supply detector tripped
    logic detector_b;    // selectable-level supply detector tripped
    logic watchdog_ovf;  // watchdog overflow, pulse
    logic crystal_lost;  // raw missing-clock detection
  } src_sources_t;

  typedef struct packed {
    logic sys_reset_n;       // system reset, active low
    logic boot_from_isp;     // fetch from in_system_programming_region
    logic crystal_selected;  // processor clock from crystal, else internal_fast_oscillator
  } src_system_t;

  typedef enum logic {SRC_RUN, SRC_HOLD} src_state_t;

endpackage : src_pkg

`default_nettype wire

/* src_top.sv */
// src_top: system reset controller with its ahb-lite register slave.
// assumes power-on reset drives hresetn, and all source inputs are synchronous to hclk
// except the external pin, which is synchronised here.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module src_top
  import src_pkg::*;
(
  // clock and power-on reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // ahb-lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // reset sources and boot strap
  input  wire src_sources_t sources,
  input  wire logic         boot_option_isp,
  // system side
  output src_system_t       system_out,
  output logic      [15:0]  boot_address
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic        dp_write_reg;
  logic        dp_read_reg;
  logic        rd_done_reg;
  logic        dp_hit_reg;
  logic [7:0]  dp_idx_reg;
  logic [31:0] hrdata_reg;
  logic [7:0]  rd_mux;
  logic        addr_ok;
  logic        wr_en;
  logic        wr_power_control_zero;
  logic        wr_flags;
  logic        wr_prog;
  logic [7:0]  wdata8;

  logic [7:0]  power_control_zero_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  flags_next;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic [7:0]  prog_reg;
  logic [7:0]  system_flag_irq_enable_reg;
  logic [7:0]  wdtc_reg;
  logic [7:0]  power_control_two_reg;
  logic        crystal_sel_reg;
  logic        soft_req_reg;

  logic        pin_meta_reg;
  logic        pin_sync_reg;
  logic [4:0]  pin_cnt_reg;
  logic        pin_req;

  logic        mcd_event;
  logic        mcd_reset;
  logic        reset_req;
  logic        warm_rst;
  src_state_t  state_reg;
  logic [2:0]  hold_cnt_reg;
  logic        sys_rst_n_reg;
  logic        boot_isp_reg;
  logic        por_done_reg;

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  // address phase taken when selected, ready and nonseq or seq
  assign addr_ok = hsel & hready & htrans[1];
  // writes finish with no wait; reads add one wait state so that a read
  // right behind a write sees the freshly written value
  assign hreadyout = ~(dp_read_reg & ~rd_done_reg);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign wdata8    = hwdata[7:0];
  assign wr_en     = dp_write_reg & dp_hit_reg;
  assign wr_power_control_zero  = wr_en & (dp_idx_reg == IDX_POWER_CONTROL_ZERO);
  assign wr_flags  = wr_en & (dp_idx_reg == IDX_FLAGS);
  assign wr_prog   = wr_en & (dp_idx_reg == IDX_PROG);

  // data phase bookkeeping; only aligned word accesses decode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write_reg <= 1'b0;
      dp_read_reg  <= 1'b0;
      dp_hit_reg   <= 1'b0;
      dp_idx_reg   <= 8'h00;
    end
    else if (addr_ok)
    begin
      dp_write_reg <= hwrite;
      dp_read_reg  <= ~hwrite;
      dp_idx_reg   <= haddr[9:2];
      dp_hit_reg   <= (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00) && (hsize == 3'b010);
    end
    else if (hreadyout)
    begin
      dp_write_reg <= 1'b0;
      dp_read_reg  <= 1'b0;
    end
  end

  // read wait state and read data capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_done_reg <= 1'b0;
      hrdata_reg  <= 32'h0000_0000;
    end
    else if (dp_read_reg && !rd_done_reg)
    begin
      rd_done_reg <= 1'b1;
      hrdata_reg  <= {24'h00_0000, rd_mux};
    end
    else
    begin
      rd_done_reg <= 1'b0;
    end
  end

  // read multiplexer; unmapped addresses read zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (dp_hit_reg)
    begin
      case (dp_idx_reg)
        IDX_POWER_CONTROL_ZERO:  rd_mux = power_control_zero_reg;
        IDX_FLAGS:  rd_mux = flags_reg & FLAGS_MASK;
        IDX_PROG:   rd_mux = prog_reg & PROG_MASK;  // trigger always reads zero
        IDX_SYSTEM_FLAG_IRQ_ENABLE:   rd_mux = system_flag_irq_enable_reg;
        IDX_WDTC:   rd_mux = wdtc_reg & WDTC_MASK;
        IDX_POWER_CONTROL_TWO:  rd_mux = power_control_two_reg & POWER_CONTROL_TWO_MASK;
        IDX_CLKSEL: rd_mux = {6'h00, boot_isp_reg, crystal_sel_reg};
        default:    rd_mux = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // external pin filter
  // ****************************************************************
  // two-flop synchroniser, then a saturating count of high samples
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_cnt_reg  <= 5'd0;
    end
    else
    begin
      pin_meta_reg <= sources.pin_level;
      pin_sync_reg <= pin_meta_reg;
      if (!pin_sync_reg)
        pin_cnt_reg <= 5'd0;  // a single low sample restarts the count
      else if (pin_cnt_reg != PIN_HOLD_CYCLES)
        pin_cnt_reg <= pin_cnt_reg + 5'd1;
    end
  end

  // short glitches never reach the system reset
  assign pin_req = (pin_cnt_reg == PIN_HOLD_CYCLES);

  // ****************************************************************
  // reset request merge
  // ****************************************************************
  // detector ignored unless enabled and the crystal is in use
  assign mcd_event = sources.crystal_lost & crystal_sel_reg & system_flag_irq_enable_reg[MCLK_IRQ_EN_BIT];
  assign mcd_reset = mcd_event & system_flag_irq_enable_reg[MCLK_RESET_EN_BIT];

  // every source of the system reset; supply, watchdog and missing-clock sources gated by their own enables
  assign reset_req = sources.por_low
                   | pin_req
                   | soft_req_reg
                   | sources.illegal_addr
                   | (sources.detector_a & power_control_two_reg[SUPPLY_A_RST_EN_BIT])
                   | (sources.detector_b & power_control_two_reg[SUPPLY_B_RST_EN_BIT])
                   | (sources.watchdog_ovf & wdtc_reg[WDOG_RESET_EN_BIT])
                   | mcd_reset;

  // ****************************************************************
  // reset stretcher
  // ****************************************************************
  // a pulse source still gives a full hold window so every register settles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg     <= SRC_HOLD;
      hold_cnt_reg  <= RST_HOLD_CYCLES;
      sys_rst_n_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        SRC_RUN:
        begin
          if (reset_req)
          begin
            state_reg     <= SRC_HOLD;
            hold_cnt_reg  <= RST_HOLD_CYCLES;
            sys_rst_n_reg <= 1'b0;
          end
        end
        SRC_HOLD:
        begin
          if (reset_req)
            hold_cnt_reg <= RST_HOLD_CYCLES;
          else if (hold_cnt_reg > 3'd1)
            hold_cnt_reg <= hold_cnt_reg - 3'd1;
          else
          begin
            hold_cnt_reg  <= 3'd0;
            state_reg     <= SRC_RUN;
            sys_rst_n_reg <= 1'b1;
          end
        end
        default:
        begin
          state_reg     <= SRC_HOLD;
          hold_cnt_reg  <= RST_HOLD_CYCLES;
          sys_rst_n_reg <= 1'b0;
        end
      endcase
    end
  end

  assign warm_rst = (state_reg == SRC_HOLD);

  // ****************************************************************
  // boot region and strap capture
  // ****************************************************************
  // the strap is caught in the first cycle after power-on release
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      por_done_reg <= 1'b0;
      boot_isp_reg <= 1'b0;
    end
    else
    begin
      por_done_reg <= 1'b1;
      if (!por_done_reg)
        boot_isp_reg <= boot_option_isp;
      else if (soft_req_reg)
        boot_isp_reg <= prog_reg[BOOT_SELECT_BIT];
      else if (reset_req && !warm_rst)
        boot_isp_reg <= boot_option_isp;
    end
  end

  assign boot_address = boot_isp_reg ? ISP_START : RESET_VECTOR;
  assign system_out   = '{sys_reset_n:      sys_rst_n_reg,
                          boot_from_isp:    boot_isp_reg,
                          crystal_selected: crystal_sel_reg};

  // ****************************************************************
  // control registers
  // ****************************************************************
  // power_control_zero: warm reset clears all but the power-on flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      power_control_zero_reg <= POWER_CONTROL_ZERO_POR;
    else
    begin
      if (warm_rst)
        power_control_zero_reg <= power_control_zero_reg & (8'h01 << POWER_ON_FLAG_BIT);
      else if (wr_power_control_zero)
        power_control_zero_reg <= wdata8;
      if (sources.por_low)
        power_control_zero_reg[POWER_ON_FLAG_BIT] <= 1'b1;  // hardware set wins
    end
  end

  // programming_control: trigger is a pulse, boot select survives warm reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prog_reg     <= PROG_POR;
      soft_req_reg <= 1'b0;
    end
    else
    begin
      soft_req_reg <= wr_prog & wdata8[SOFT_TRIGGER_BIT];  // writing zero does nothing
      if (warm_rst)
      begin
        prog_reg[PROG_ENABLE_BIT] <= 1'b0;
        prog_reg[PROG_FAIL_BIT]   <= 1'b0;
      end
      else if (wr_prog)
        prog_reg <= wdata8 & PROG_MASK;
    end
  end

  // enables are power-on state, so a brown-out reset cannot disarm itself
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      system_flag_irq_enable_reg  <= SYSTEM_FLAG_IRQ_ENABLE_POR;  // missing-clock reset on by default
      wdtc_reg  <= WDTC_POR;
      power_control_two_reg <= POWER_CONTROL_TWO_POR;
    end
    else if (wr_en)
    begin
      if (dp_idx_reg == IDX_SYSTEM_FLAG_IRQ_ENABLE)
        system_flag_irq_enable_reg <= wdata8;
      if (dp_idx_reg == IDX_WDTC)
        wdtc_reg <= wdata8 & WDTC_MASK;
      if (dp_idx_reg == IDX_POWER_CONTROL_TWO)
        power_control_two_reg <= wdata8 & POWER_CONTROL_TWO_MASK;
    end
  end

  // clock select: crystal only reselectable once the missing-clock flag is cleared
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      crystal_sel_reg <= 1'b0;
    else if (mcd_reset)
      crystal_sel_reg <= 1'b0;  // fall back to the internal oscillator
    else if (wr_en && (dp_idx_reg == IDX_CLKSEL) && !flags_reg[MCLK_FLAG_BIT])
      crystal_sel_reg <= wdata8[CRYSTAL_SEL_BIT];
  end

  // ****************************************************************
  // cause flags
  // ****************************************************************
  // hardware set wins over a write-one clear in the same cycle
  always_comb
  begin
    flag_set                    = 8'h00;
    flag_set[SOFT_CAUSE_BIT]    = soft_req_reg;
    flag_set[PIN_FLAG_BIT]      = pin_req;
    flag_set[MCLK_FLAG_BIT]     = mcd_event;
    flag_set[SUPPLY_B_FLAG_BIT] = sources.detector_b;
    flag_set[SUPPLY_A_FLAG_BIT] = sources.detector_a;
    flag_set[WDOG_FLAG_BIT]     = sources.watchdog_ovf;
    flag_clr                    = wr_flags ? (wdata8 & FLAGS_MASK) : 8'h00;
    flags_next                  = (flags_reg & ~flag_clr) | flag_set;
  end

  // flags keep their value through warm resets so software can read the cause
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_reg <= FLAGS_POR;
    else
      flags_reg <= flags_next;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_por_holds_reset: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sources.por_low |=> !system_out.sys_reset_n)
    else $error("system reset not held during low supply");

  a_reset_stretch: assert property (
    @(posedge hclk) disable iff (!hresetn)
    reset_req |=> (!system_out.sys_reset_n) [*4])
    else $error("system reset shorter than hold window");

  a_soft_trigger: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_prog && wdata8[SOFT_TRIGGER_BIT]) |=> ##1 !system_out.sys_reset_n)
    else $error("soft trigger did not reset the system");

  a_soft_flag_boot: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (soft_req_reg && por_done_reg) |=>
      flags_reg[SOFT_CAUSE_BIT] && (boot_isp_reg == $past(prog_reg[BOOT_SELECT_BIT])))
    else $error("soft reset cause or boot region wrong");

  a_flag_write_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_flags && !wdata8[PIN_FLAG_BIT] && flags_reg[PIN_FLAG_BIT]) |=> flags_reg[PIN_FLAG_BIT])
    else $error("writing zero cleared a cause flag");

  a_pin_filter: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !pin_sync_reg |=> !pin_req ##1 !pin_req)
    else $error("pin request without consecutive high samples");

  a_pin_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(pin_req) |=> flags_reg[PIN_FLAG_BIT] && !system_out.sys_reset_n)
    else $error("pin reset did not set its flag");

  a_wdog_reset: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (sources.watchdog_ovf && wdtc_reg[WDOG_RESET_EN_BIT]) |=>
      flags_reg[WDOG_FLAG_BIT] && !system_out.sys_reset_n)
    else $error("watchdog overflow did not reset");

  a_mcd_switch: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mcd_reset |=> !system_out.crystal_selected && flags_reg[MCLK_FLAG_BIT]
                  && !system_out.sys_reset_n)
    else $error("missing clock did not fall back to internal oscillator");

  a_mcd_inactive: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!system_flag_irq_enable_reg[MCLK_IRQ_EN_BIT] && !flags_reg[MCLK_FLAG_BIT]) |=> !flags_reg[MCLK_FLAG_BIT])
    else $error("disabled missing-clock detector set its flag");

endmodule : src_top

`default_nettype wire

/* src_far_model.sv */
// src_far_model: reset pin driver and supply monitors beside the controller.
// assumes hold() is called just after a rising edge of hclk.
`timescale 1ns/1ns
`default_nettype none

module src_far_model
  import src_pkg::*;
(
  // clock
  input  wire logic   hclk,
  // source lines, msb first as the package orders them
  output var src_sources_t src_o
);
  // ****
  // drive one source
  // ****
  // all lines idle low until a scenario raises one
  initial src_o = '0;

  // raise a line for n edges, then release it low (pin held 24+ for a request)
  task automatic hold(input int s, input int n);
    src_o[s] <= 1'b1;
    repeat (n) @(posedge hclk);
    src_o[s] <= 1'b0;
  endtask : hold

endmodule : src_far_model
`default_nettype wire

/* src_top_bench.sv */
// src_top_bench: self-checking bench of the system reset controller.
// assumes src_top as the only ahb-lite slave and src_far_model on its sources.
`timescale 1ns/1ns
`default_nettype none

module src_top_bench;
  import src_pkg::*;
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, rst_seen, boot_strap;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [1:0]   htrans;
  logic [15:0]  boot_address;
  logic [7:0]   rd, r;
  src_sources_t sources;
  src_system_t  system_out;
  int           fail_count = 0;
  int           checks = 0;
  int           mdl_flags = 0;
  logic [7:0]   ri[8] = '{IDX_POWER_CONTROL_ZERO, IDX_FLAGS, IDX_PROG, IDX_SYSTEM_FLAG_IRQ_ENABLE, IDX_WDTC, IDX_POWER_CONTROL_TWO,
                          IDX_CLKSEL, 8'h00};
  logic [7:0]   rv[8] = '{POWER_CONTROL_ZERO_POR, FLAGS_POR, PROG_POR, SYSTEM_FLAG_IRQ_ENABLE_POR, WDTC_POR, POWER_CONTROL_TWO_POR,
                          8'h00, 8'h00};

  // ****
  // design and far side
  // ****
  src_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sources(sources), .boot_option_isp(boot_strap),
    .system_out(system_out), .boot_address(boot_address));
  src_far_model far (.hclk(hclk), .src_o(sources));

  // 4 ns clock
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // remember any system reset seen since the scenario began; sampled mid-cycle,
  // away from the edge that launches it
  always @(negedge hclk) if (system_out.sys_reset_n === 1'b0) rst_seen <= 1'b1;

  // ****
  // tasks
  // ****
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // hready is combinational and inputs move only at rising edges, so the
  // level seen at the falling edge is the level sampled at the next rise
  task automatic rdy;
    int n;
    for (n = 0; n < 200; n++)
    begin
      @(negedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 200) fail_count++;
    if (n == 200) end_of_test;
    rd = hrdata[7:0];
  endtask : rdy

  // one single word transfer; entered and left just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    rdy;
    @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    rdy;
    @(posedge hclk);
  endtask : xfer

  task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    cmp(16'({hresp, rd}), 16'(exp));  // response must stay okay alongside the data
  endtask : chk

  // wait out any system reset; the hold after a request is a few cycles
  task automatic settle;
    int n;
    for (n = 0; n < 80; n++)
    begin
      @(negedge hclk);
      if (n >= 8 && system_out.sys_reset_n === 1'b1) break;
    end
    if (n == 80) fail_count++;
    if (n == 80) end_of_test;
    @(posedge hclk);
  endtask : settle

  // flag model: set by the event, untouched by a zero write, cleared by ones
  task automatic fl(input logic [7:0] f);
    mdl_flags |= f;
    xfer(1'b1, IDX_FLAGS, 8'h00);
    chk(IDX_FLAGS, 8'(mdl_flags));
    xfer(1'b1, IDX_FLAGS, f);
    mdl_flags &= ~f;
    chk(IDX_FLAGS, 8'(mdl_flags));
  endtask : fl

  // raise source s for n cycles, then check reset and flags
  task automatic ev(input int s, input int n, input logic rst, input logic [7:0] f);
    rst_seen = 1'b0;
    far.hold(s, n);
    settle;
    cmp(16'(rst_seen), 16'(rst));
    fl(f);
    $display("test source %0d length %0d done", s, n);
  endtask : ev

  // ****
  // main sequence
  // ****
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    rst_seen = 1'b0;
    boot_strap = 1'b0;
    void'($urandom(32'h0f459843));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    for (int i = 0; i < 8; i++) chk(ri[i], rv[i]);
    $display("test reset values done");
    // soft reset with either boot region; power_control_zero keeps only its power-on bit
    for (int b = 0; b < 2; b++)
    begin
      r = 8'($urandom);
      xfer(1'b1, IDX_POWER_CONTROL_ZERO, r);
      chk(IDX_POWER_CONTROL_ZERO, r);
      rst_seen = 1'b0;
      xfer(1'b1, IDX_PROG, 8'(32 + 64 * b));
      settle;
      cmp(16'(rst_seen), 16'd1);
      cmp(boot_address, b ? ISP_START : RESET_VECTOR);
      cmp(16'(system_out.boot_from_isp), 16'(b));
      chk(IDX_POWER_CONTROL_ZERO, r & 8'h10);
      chk(IDX_PROG, 8'(64 * b));
      fl(8'h80);
      $display("test soft reset %0d done", b);
    end
    ev(5, $urandom_range(22, 1), 1'b0, 8'h00);
    ev(5, $urandom_range(60, 30), 1'b1, 8'h40);
    cmp(boot_address, RESET_VECTOR);
    xfer(1'b1, IDX_POWER_CONTROL_TWO, 8'h02);
    ev(3, 2, 1'b1, 8'h02);
    ev(2, 2, 1'b0, 8'h04);
    xfer(1'b1, IDX_POWER_CONTROL_TWO, 8'h0a);
    ev(2, 2, 1'b1, 8'h04);
    ev(1, 1, 1'b0, 8'h01);
    xfer(1'b1, IDX_WDTC, 8'h80);
    ev(1, 1, 1'b1, 8'h01);
    boot_strap <= 1'b1;
    ev(4, 1, 1'b1, 8'h00);
    cmp(boot_address, ISP_START);
    boot_strap <= 1'b0;
    xfer(1'b1, IDX_POWER_CONTROL_ZERO, 8'h00);
    ev(6, 3, 1'b1, 8'h00);
    chk(IDX_POWER_CONTROL_ZERO, 8'h10);
    // missing clock: reset by default, flag only, then detector off
    xfer(1'b1, IDX_CLKSEL, 8'h01);
    ev(0, 2, 1'b1, 8'h20);
    cmp(16'(system_out.crystal_selected), 16'd0);
    xfer(1'b1, IDX_SYSTEM_FLAG_IRQ_ENABLE, 8'h20);
    xfer(1'b1, IDX_CLKSEL, 8'h01);  // flag already cleared by software
    ev(0, 2, 1'b0, 8'h20);
    cmp(16'(system_out.crystal_selected), 16'd1);
    xfer(1'b1, IDX_SYSTEM_FLAG_IRQ_ENABLE, 8'h00);
    ev(0, 2, 1'b0, 8'h00);
    end_of_test;
  end

endmodule : src_top_bench
`default_nettype wire
